// >>> core/rx_flow_ctrl.v
// Receive FIFO automatic flow controller for a 10/100 Ethernet MAC.
// Assumes FIFO level, duplex, speed, frame events and transmit
// acknowledge all come from MAC logic on CLK_SYS.
`timescale 1ns/10ps
`include "afc_map.vh"

module rx_flow_ctrl #(
  parameter        LEVEL_W   = 14,
  parameter [15:0] BASE_CYC  = `AFC_JAM_BASE_CYC,
  parameter [15:0] STEP_CYC  = `AFC_JAM_STEP_CYC,
  parameter [15:0] EXTRA_CYC = `AFC_JAM_10M_EXTRA_CYC
) (
  input  wire               CLK_SYS,
  input  wire               SYS_RST,
  // Register port
  input  wire [7:0]         ADDR,
  input  wire [31:0]        WDATA,
  input  wire               WR,
  input  wire               RD,
  output wire [31:0]        RDATA,
  // MAC status and receive events
  input  wire [LEVEL_W-1:0] RX_FIFO_LEVEL,
  input  wire               FULL_DUPLEX,
  input  wire               SPEED_100,
  input  wire               RX_PREAMBLE,
  input  wire               RX_DA_VALID,
  input  wire               RX_DA_MCAST,
  input  wire               RX_DA_BCAST,
  input  wire               RX_DA_OWN,
  // Requests toward the MAC transmitter
  input  wire               TX_PAUSE_ACK,
  output wire               PAUSE_REQ,
  output wire               PAUSE_ZERO,
  output wire               JAM
);

  // ==========================================================
  // Configuration fields
  // Written only through the configuration word
  reg  [7:0]         fifo_high_threshold_r;
  reg  [7:0]         fifo_low_threshold_r;
  reg  [3:0]         jam_duration_code_r;
  reg                multicast_flow_trigger_r;
  reg                broadcast_flow_trigger_r;
  reg                own_address_flow_trigger_r;
  reg                any_frame_flow_trigger_r;

  // Flow state
  // paused_r marks a timed pause sent and no zero pause yet
  reg                pause_req_r;
  reg                pause_req_nxt;
  reg                pause_zero_r;
  reg                pause_zero_nxt;
  reg                paused_r;
  reg                paused_nxt;
  reg  [31:0]        rdata_r;
  reg  [31:0]        rdata_nxt;

  wire [LEVEL_W+1:0] level_ext;
  wire [LEVEL_W+1:0] hi_bytes;
  wire [LEVEL_W+1:0] lo_bytes;
  wire               above_hi;
  wire               below_lo;
  wire               fd_enabled;
  wire               hd_match;
  wire               hd_trigger;
  wire               jam_busy;
  wire [2:0]         frame_class;
  wire [2:0]         class_enable;
  wire [2:0]         class_hit;
  wire               cfg_sel;
  wire               stat_sel;

  // ==========================================================
  // Field reset values, cut from the packed reset word so that
  // one header constant sets them all
  localparam [23:0]  cfg_reset_val  = `AFC_CFG_RESET;
  localparam [7:0]   hi_reset_val   = cfg_reset_val[`FIFO_HIGH_THRESHOLD_MSB:`FIFO_HIGH_THRESHOLD_LSB];
  localparam [7:0]   lo_reset_val   = cfg_reset_val[`FIFO_LOW_THRESHOLD_MSB:`FIFO_LOW_THRESHOLD_LSB];
  localparam [3:0]   dur_reset_val  = cfg_reset_val[`AFC_DUR_MSB:`AFC_DUR_LSB];
  localparam [0:0]   mult_reset_val = cfg_reset_val[`AFC_MULT_BIT];
  localparam [0:0]   brd_reset_val  = cfg_reset_val[`AFC_BRD_BIT];
  localparam [0:0]   own_reset_val  = cfg_reset_val[`AFC_OWN_BIT];
  localparam [0:0]   any_reset_val  = cfg_reset_val[`AFC_ANY_BIT];

  // ==========================================================
  // Threshold compare
  // Compared every cycle against the live level; the high and low
  // thresholds give the hysteresis, nothing here filters the level
  // Thresholds scale by 64 bytes; widened so 8'hFF never wraps
  function [LEVEL_W+1:0] units_to_bytes;
    input [7:0] units;
    reg   [31:0] b;
    begin
      b = {24'h000000, units} << `AFC_UNIT_SHIFT;
      units_to_bytes = b[LEVEL_W+1:0];
    end
  endfunction

  assign level_ext = {2'b00, RX_FIFO_LEVEL};
  assign hi_bytes  = units_to_bytes(fifo_high_threshold_r);
  assign lo_bytes  = units_to_bytes(fifo_low_threshold_r);
  assign above_hi  = (level_ext >= hi_bytes);
  assign below_lo  = (level_ext < lo_bytes);

  // ==========================================================
  // Trigger qualification
  // Half duplex never requests a pause; backpressure is its only
  // lever there, and full duplex never jams
  // Full duplex looks only at the any-frame bit
  assign fd_enabled = FULL_DUPLEX & any_frame_flow_trigger_r;

  // Per-class match of the decoded address; the three classes are
  // alike, so one loop builds them
  assign frame_class  = {RX_DA_MCAST, RX_DA_BCAST, RX_DA_OWN};
  assign class_enable = {multicast_flow_trigger_r, broadcast_flow_trigger_r,
                         own_address_flow_trigger_r};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_class
      assign class_hit[gi] = frame_class[gi] & class_enable[gi];
    end
  endgenerate

  // Frame selection bits are don't-care once any-frame is set
  assign hd_match = any_frame_flow_trigger_r ? 1'b0 : (|class_hit);

  // Any-frame fires on the preamble, before the address is known,
  // so the reaction starts within the first cycles of the frame
  assign hd_trigger = ~FULL_DUPLEX & above_hi &
                      ((any_frame_flow_trigger_r & RX_PREAMBLE) |
                       (RX_DA_VALID & hd_match));

  // ==========================================================
  // Backpressure timer
  // Speed is sampled when a window starts; a speed change in mid-jam
  // takes effect with the next trigger. Retrigger restarts the window
  jam_timer #(
    .BASE_CYC  (BASE_CYC),
    .STEP_CYC  (STEP_CYC),
    .EXTRA_CYC (EXTRA_CYC)
  ) u_jam_timer (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .start     (hd_trigger),
    .code      (jam_duration_code_r),
    .speed_100 (SPEED_100),
    .busy      (jam_busy)
  );

  // ==========================================================
  // Pause request sequencing
  // One request is outstanding at most; a new one waits for the
  // acknowledge, so a frame already on the wire is never cut short
  // Paused state drops with the enable: a later re-enable starts
  // clean and sends a timed pause first, never a lone zero pause
  always @* begin
    pause_req_nxt  = pause_req_r;
    pause_zero_nxt = pause_zero_r;
    paused_nxt     = paused_r;
    if (pause_req_r && TX_PAUSE_ACK) begin
      pause_req_nxt = 1'b0;
    end
    if (!fd_enabled) begin
      // Leaving full duplex or disabling drops the pause history
      paused_nxt = 1'b0;
    end else if (!pause_req_r) begin
      if (!paused_r && above_hi) begin
        pause_req_nxt  = 1'b1;
        pause_zero_nxt = 1'b0;
        paused_nxt     = 1'b1;
      end else if (paused_r && below_lo) begin
        pause_req_nxt  = 1'b1;
        pause_zero_nxt = 1'b1;
        paused_nxt     = 1'b0;
      end
    end
  end

  // Pause state flops
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pause_req_r  <= 1'b0;
      pause_zero_r <= 1'b0;
      paused_r     <= 1'b0;
    end else begin
      pause_req_r  <= pause_req_nxt;
      pause_zero_r <= pause_zero_nxt;
      paused_r     <= paused_nxt;
    end
  end

  // ==========================================================
  // Address decode
  // Shared by the write and read paths so the two can never
  // disagree on which word an address selects
  function is_cfg_addr;
    input [7:0] a;
    begin
      is_cfg_addr = (a == `AFC_CFG_OFFSET);
    end
  endfunction

  function is_stat_addr;
    input [7:0] a;
    begin
      is_stat_addr = (a == `AFC_STAT_OFFSET);
    end
  endfunction

  assign cfg_sel  = is_cfg_addr(ADDR);
  assign stat_sel = is_stat_addr(ADDR);

  // ==========================================================
  // Register writes
  // Only the configuration word is writable; status is read-only
  // A write to the status word or an unmapped address falls
  // through and changes nothing
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fifo_high_threshold_r      <= hi_reset_val;
      fifo_low_threshold_r       <= lo_reset_val;
      jam_duration_code_r        <= dur_reset_val;
      multicast_flow_trigger_r   <= mult_reset_val;
      broadcast_flow_trigger_r   <= brd_reset_val;
      own_address_flow_trigger_r <= own_reset_val;
      any_frame_flow_trigger_r   <= any_reset_val;
    end else if (WR && cfg_sel) begin
      fifo_high_threshold_r      <= WDATA[`FIFO_HIGH_THRESHOLD_MSB:`FIFO_HIGH_THRESHOLD_LSB];
      fifo_low_threshold_r       <= WDATA[`FIFO_LOW_THRESHOLD_MSB:`FIFO_LOW_THRESHOLD_LSB];
      jam_duration_code_r        <= WDATA[`AFC_DUR_MSB:`AFC_DUR_LSB];
      multicast_flow_trigger_r   <= WDATA[`AFC_MULT_BIT];
      broadcast_flow_trigger_r   <= WDATA[`AFC_BRD_BIT];
      own_address_flow_trigger_r <= WDATA[`AFC_OWN_BIT];
      any_frame_flow_trigger_r   <= WDATA[`AFC_ANY_BIT];
    end
  end

  // ==========================================================
  // Register reads
  // Data stands one cycle after the strobe, zero otherwise and
  // for unmapped addresses; reserved bits read as zero
  // Status is a live snapshot: level and flags may have moved by
  // the time software looks at them
  always @* begin
    rdata_nxt = 32'h00000000;
    if (RD) begin
      case ({cfg_sel, stat_sel})
        2'b10: begin
          rdata_nxt[`FIFO_HIGH_THRESHOLD_MSB:`FIFO_HIGH_THRESHOLD_LSB]   = fifo_high_threshold_r;
          rdata_nxt[`FIFO_LOW_THRESHOLD_MSB:`FIFO_LOW_THRESHOLD_LSB]   = fifo_low_threshold_r;
          rdata_nxt[`AFC_DUR_MSB:`AFC_DUR_LSB] = jam_duration_code_r;
          rdata_nxt[`AFC_MULT_BIT]             = multicast_flow_trigger_r;
          rdata_nxt[`AFC_BRD_BIT]              = broadcast_flow_trigger_r;
          rdata_nxt[`AFC_OWN_BIT]              = own_address_flow_trigger_r;
          rdata_nxt[`AFC_ANY_BIT]              = any_frame_flow_trigger_r;
        end
        2'b01: begin
          rdata_nxt[`AFC_ST_PAUSE_REQ_BIT]  = pause_req_r;
          rdata_nxt[`AFC_ST_PAUSE_ZERO_BIT] = pause_zero_r;
          rdata_nxt[`AFC_ST_PAUSED_BIT]     = paused_r;
          rdata_nxt[`AFC_ST_JAM_BIT]        = jam_busy;
          rdata_nxt[`AFC_ST_ABOVE_HI_BIT]   = above_hi;
          rdata_nxt[`AFC_ST_LEVEL_LSB+LEVEL_W-1:`AFC_ST_LEVEL_LSB] = RX_FIFO_LEVEL;
        end
        default: begin
          rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  // Read data register; cleared in every cycle without a read
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  // Register port
  assign RDATA      = rdata_r;

  // Transmit requests
  assign PAUSE_REQ  = pause_req_r;
  assign PAUSE_ZERO = pause_zero_r; // Zero means send time 0, else pause_time_value

  // Backpressure
  assign JAM        = jam_busy;     // Flop inside the timer

endmodule

// >>> core/afc_map.vh
// Constants for the receive FIFO automatic flow controller.
// Assumes a 20 MHz system clock and a word-wide register port.
`ifndef AFC_MAP_VH
`define AFC_MAP_VH

// ==========================================================
// Register offsets (byte addresses on the register port)
`define AFC_CFG_OFFSET        8'h00
`define AFC_STAT_OFFSET       8'h04

// ==========================================================
// Configuration register fields
`define FIFO_HIGH_THRESHOLD_MSB            23
`define FIFO_HIGH_THRESHOLD_LSB            16
`define FIFO_LOW_THRESHOLD_MSB            15
`define FIFO_LOW_THRESHOLD_LSB            8
`define AFC_DUR_MSB           7
`define AFC_DUR_LSB           4
`define AFC_MULT_BIT          3
`define AFC_BRD_BIT           2
`define AFC_OWN_BIT           1
`define AFC_ANY_BIT           0
`define AFC_CFG_RESET         24'h000000

// ==========================================================
// Status register fields
`define AFC_ST_PAUSE_REQ_BIT  0
`define AFC_ST_PAUSE_ZERO_BIT 1
`define AFC_ST_PAUSED_BIT     2
`define AFC_ST_JAM_BIT        3
`define AFC_ST_ABOVE_HI_BIT   4
`define AFC_ST_LEVEL_LSB      16

// ==========================================================
// Threshold granularity: one unit is 64 bytes
`define AFC_UNIT_SHIFT        6

// ==========================================================
// Timing: 50 ns clock, 5 us base, 50 us step, 2.2 us at 10 Mb/s
// Sized 16 bits so the derived cycle counts fit the timer as is
`define AFC_CLK_PERIOD_NS     16'h0032
`define AFC_JAM_BASE_NS       16'h1388
`define AFC_JAM_STEP_NS       16'hC350
`define AFC_JAM_10M_EXTRA_NS  16'h0898
`define AFC_JAM_BASE_CYC      (`AFC_JAM_BASE_NS / `AFC_CLK_PERIOD_NS)
`define AFC_JAM_STEP_CYC      (`AFC_JAM_STEP_NS / `AFC_CLK_PERIOD_NS)
`define AFC_JAM_10M_EXTRA_CYC (`AFC_JAM_10M_EXTRA_NS / `AFC_CLK_PERIOD_NS)

`endif

// >>> core/jam_timer.v
// Backpressure timer: converts a duration code into a jam window.
// Assumes start pulses and code come from logic on the same clock.
`timescale 1ns/10ps
`include "afc_map.vh"

module jam_timer #(
  parameter [15:0] BASE_CYC  = `AFC_JAM_BASE_CYC,
  parameter [15:0] STEP_CYC  = `AFC_JAM_STEP_CYC,
  parameter [15:0] EXTRA_CYC = `AFC_JAM_10M_EXTRA_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire [3:0]  code,
  input  wire        speed_100,
  output wire        busy
);

  reg  [15:0] count_r;
  reg  [15:0] count_nxt;
  reg         busy_r;
  reg         busy_nxt;
  wire [15:0] load_cyc;

  // ==========================================================
  // Duration lookup
  // Codes 0..3 are 1,2,3,5 base steps; 4..F are (code-3) long steps
  function [15:0] jam_cycles;
    input [3:0]  c;
    input        fast;
    reg   [31:0] t;
    begin
      case (c)
        4'h0: t = {16'h0000, BASE_CYC};
        4'h1: t = {16'h0000, BASE_CYC} * 32'h2;
        4'h2: t = {16'h0000, BASE_CYC} * 32'h3;
        4'h3: t = {16'h0000, BASE_CYC} * 32'h5;
        default: t = {16'h0000, STEP_CYC} * ({28'h0000000, c} - 32'h3);
      endcase
      if (!fast) begin
        t = t + {16'h0000, EXTRA_CYC};
      end
      jam_cycles = t[15:0];
    end
  endfunction

  assign load_cyc = jam_cycles(code, speed_100);

  // ==========================================================
  // Countdown; busy stands exactly load_cyc cycles after start
  always @* begin
    count_nxt = count_r;
    busy_nxt  = 1'b0;
    if (start) begin
      count_nxt = load_cyc;  // Retrigger restarts the window
      busy_nxt  = 1'b1;
    end else if (count_r != 16'h0000) begin
      count_nxt = count_r - 16'h0001;
      busy_nxt  = (count_r > 16'h0001);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= 16'h0000;
      busy_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign busy = busy_r;

endmodule

// >>> tb/afc_props_properties.sv
// Port assertions for the receive flow controller.
// Assumes config is mirrored from writes to offset 00h.
`timescale 1ns/10ps
module afc_props #(
  parameter LEVEL_W = 14
) (
  input wire               CLK_SYS,
  input wire               SYS_RST,
  input wire [7:0]         ADDR,
  input wire [31:0]        WDATA,
  input wire               WR,
  input wire               RD,
  input wire [31:0]        RDATA,
  input wire [LEVEL_W-1:0] RX_FIFO_LEVEL,
  input wire               FULL_DUPLEX,
  input wire               RX_PREAMBLE,
  input wire               RX_DA_VALID,
  input wire               TX_PAUSE_ACK,
  input wire               PAUSE_REQ,
  input wire               PAUSE_ZERO,
  input wire               JAM
);
  // ====
  // Config mirror, live one cycle after the write like the block
  reg  [23:0] cfg_r;
  wire        any_f  = cfg_r[0];
  wire        hi_hit = RX_FIFO_LEVEL >= {cfg_r[23:16], 6'h00};
  wire        lo_low = RX_FIFO_LEVEL < {cfg_r[15:8], 6'h00};
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST)
      cfg_r <= 24'h000000;
    else if (WR && ADDR == 8'h00)
      cfg_r <= WDATA[23:0];
  end
  // ====
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_req_up;
    !PAUSE_REQ ##1 PAUSE_REQ;
  endsequence
  sequence s_hd_trig;
    !FULL_DUPLEX && any_f && hi_hit && RX_PREAMBLE;
  endsequence
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h00000000)
    else $error("read data not zero outside read slot");
  a_req_hold: assert property (PAUSE_REQ && !TX_PAUSE_ACK |=> PAUSE_REQ && $stable(PAUSE_ZERO))
    else $error("pause request dropped before ack");
  a_req_drop: assert property (PAUSE_REQ && TX_PAUSE_ACK |=> !PAUSE_REQ)
    else $error("pause request kept after ack");
  a_pause_enable: assert property (s_req_up |-> $past(FULL_DUPLEX) && $past(any_f))
    else $error("pause raised without full duplex any-frame");
  a_pause_high: assert property (s_req_up ##0 !PAUSE_ZERO |-> $past(hi_hit))
    else $error("timed pause below high level");
  a_pause_low: assert property (s_req_up ##0 PAUSE_ZERO |-> $past(lo_low))
    else $error("zero pause not below low level");
  a_jam_start: assert property (s_hd_trig |=> JAM)
    else $error("no jam after preamble trigger");
  a_jam_half: assert property ($rose(JAM) |-> !$past(FULL_DUPLEX))
    else $error("jam started in full duplex");
  a_any_nodecode: assert property (any_f && RX_DA_VALID && !RX_PREAMBLE && !JAM |=> !JAM)
    else $error("address decode jammed with any-frame set");
endmodule
bind rx_flow_ctrl afc_props #(.LEVEL_W(LEVEL_W)) u_props (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .RX_FIFO_LEVEL(RX_FIFO_LEVEL), .FULL_DUPLEX(FULL_DUPLEX), .RX_PREAMBLE(RX_PREAMBLE), .RX_DA_VALID(RX_DA_VALID),
  .TX_PAUSE_ACK(TX_PAUSE_ACK), .PAUSE_REQ(PAUSE_REQ), .PAUSE_ZERO(PAUSE_ZERO), .JAM(JAM));

// >>> tb/mac_tx_model.sv
// MAC transmitter stand-in: takes pending pause frames.
// Assumes req is the block's pause request on the same clock.
`timescale 1ns/10ps
module mac_tx_model (
  input wire       clk,
  input wire       rst,
  input wire       req,
  input wire [3:0] gap,
  output reg       ack
);
  reg [3:0] busy_r;
  // ====
  // Wait out a frame in flight of gap cycles, never abort it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack    <= 1'b0;
      busy_r <= 4'h0;
    end else begin
      ack <= 1'b0;
      if (req && !ack) begin
        if (busy_r >= gap) begin
          ack    <= 1'b1;
          busy_r <= 4'h0;
        end else
          busy_r <= busy_r + 4'h1;
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the receive flow controller.
// Assumes short jam parameters 4, 8 and 2 cycles.
`timescale 1ns/10ps
module tb_top;
  localparam B = 4, S = 8, E = 2;
  reg         CLK_SYS, SYS_RST, WR, RD, FULL_DUPLEX, SPEED_100;
  reg         RX_PREAMBLE, RX_DA_VALID, RX_DA_MCAST, RX_DA_BCAST, RX_DA_OWN;
  reg  [7:0]  ADDR;
  reg  [31:0] WDATA, v, w;
  reg  [13:0] RX_FIFO_LEVEL;
  reg  [3:0]  gap;
  wire [31:0] RDATA;
  wire        TX_PAUSE_ACK, PAUSE_REQ, PAUSE_ZERO, JAM;
  integer     mismatches, checked, seed, cyc, k, n;
  rx_flow_ctrl #(.BASE_CYC(16'h0004), .STEP_CYC(16'h0008), .EXTRA_CYC(16'h0002)) DUT (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_FIFO_LEVEL(RX_FIFO_LEVEL), .FULL_DUPLEX(FULL_DUPLEX), .SPEED_100(SPEED_100), .RX_PREAMBLE(RX_PREAMBLE),
    .RX_DA_VALID(RX_DA_VALID), .RX_DA_MCAST(RX_DA_MCAST), .RX_DA_BCAST(RX_DA_BCAST), .RX_DA_OWN(RX_DA_OWN),
    .TX_PAUSE_ACK(TX_PAUSE_ACK), .PAUSE_REQ(PAUSE_REQ), .PAUSE_ZERO(PAUSE_ZERO), .JAM(JAM));
  mac_tx_model MAC (.clk(CLK_SYS), .rst(SYS_RST), .req(PAUSE_REQ), .gap(gap), .ack(TX_PAUSE_ACK));
  // ====
  // Clock and hang guard, ceiling well above the planned run
  always #25 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  // ====
  // Reference model and helpers
  function integer jam_n(input integer c, input integer f);
    jam_n = (c < 4 ? (c == 3 ? 5 : c + 1) * B : (c - 3) * S) + (f ? 0 : E);
  endfunction
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge CLK_SYS);
      ADDR <= a; WDATA <= d; WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge CLK_SYS);
      ADDR <= a; RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 d = RDATA;
    end
  endtask
  // One frame event: preamble, or decoded address of a class
  task frame(input pre, input [2:0] cls, output integer m);
    begin
      @(posedge CLK_SYS);
      RX_PREAMBLE <= pre; RX_DA_VALID <= ~pre;
      {RX_DA_MCAST, RX_DA_BCAST, RX_DA_OWN} <= cls;
      @(posedge CLK_SYS);
      RX_PREAMBLE <= 1'b0; RX_DA_VALID <= 1'b0;
      #1 m = 0;
      while (JAM === 1'b1 && m < 2000) begin
        m = m + 1;
        @(posedge CLK_SYS) #1;
      end
    end
  endtask
  // Bounded wait for a pause request, then for the ack to clear it
  task req_chk(input [31:0] z);
    begin
      n = 0;
      while (PAUSE_REQ !== 1'b1 && n < 20) begin
        @(posedge CLK_SYS) #1 n = n + 1;
      end
      chk("pause_req", 1, PAUSE_REQ); chk("pause_zero", z, PAUSE_ZERO);
      while (PAUSE_REQ !== 1'b0 && n < 60) begin
        @(posedge CLK_SYS) #1 n = n + 1;
      end
    end
  endtask
  task results;
    begin
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ====
  // Main sequence
  initial begin
    CLK_SYS = 0; SYS_RST = 1; WR = 0; RD = 0; ADDR = 0; WDATA = 0; FULL_DUPLEX = 1; SPEED_100 = 1;
    RX_PREAMBLE = 0; RX_DA_VALID = 0; RX_DA_MCAST = 0; RX_DA_BCAST = 0; RX_DA_OWN = 0;
    RX_FIFO_LEVEL = 0; gap = 4'h8; mismatches = 0; checked = 0; cyc = 0; seed = 32'h48578AFC;
    repeat (20) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    rd(8'h00, v); chk("cfg_reset", 0, v);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, v); chk("status", 32'h00000010, v);
    rd(8'h40, v); chk("unmapped", 0, v);
    v = $random(seed);
    wr(8'h00, v);
    rd(8'h00, w); chk("cfg_rw", v & 32'h00FFFFFF, w);
    // Class bits alone never enable full duplex pause
    wr(8'h00, 32'h0002010E);
    RX_FIFO_LEVEL <= 14'h0080 + ($random(seed) & 14'h0FFF);
    repeat (6) @(posedge CLK_SYS);
    #1 chk("no_pause", 0, PAUSE_REQ);
    wr(8'h00, 32'h00020101);
    RX_FIFO_LEVEL <= 14'h007F;
    repeat (6) @(posedge CLK_SYS);
    #1 chk("below_hi", 0, PAUSE_REQ);
    @(posedge CLK_SYS) RX_FIFO_LEVEL <= 14'h0080;
    req_chk(0);
    gap <= 4'h0; RX_FIFO_LEVEL <= 14'h003F;
    req_chk(1);
    // Half duplex: every code at both speeds
    // Level exactly at a 64-byte high threshold: reaching it is enough
    FULL_DUPLEX <= 1'b0; RX_FIFO_LEVEL <= 14'h0040;
    for (k = 0; k < 32; k = k + 1) begin
      wr(8'h00, 32'h00010001 | ((k % 16) << 4));
      SPEED_100 <= (k < 16);
      frame(1, 3'h0, n); chk("jam_len", jam_n(k % 16, k < 16), n);
    end
    // Each class jams only while any-frame is clear
    for (k = 0; k < 3; k = k + 1) begin
      wr(8'h00, 32'h00010001 | (2 << k));
      frame(0, 3'h1 << k, n); chk("any_skip", 0, n);
      wr(8'h00, 32'h00010000 | (2 << k));
      frame(0, 3'h1 << k, n); chk("class_jam", jam_n(0, 0), n);
    end
    results;
  end
endmodule
